/* hw/swrc_pin_filter.sv */
// Three-stage pin synchroniser with an agreement filter.
// Assumes asynchronous pins; the output moves only when stages two and three
// agree, so a single-cycle glitch after the first stage is never passed on.
`default_nettype none

module swrc_pin_filter #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Raw pins and filtered levels.
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            level_q <= RST;
        end else begin
            for (int i = 0; i < int'(W); i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

/* hw/swrc_pkg.sv */
// Shared constants, types and decoding for the serial wiper register logic.
// Assumes a single 125 MHz system clock; all pins are sampled by that clock.
`default_nettype none

package swrc_pkg;

    // System clock and timing.
    localparam int unsigned CLK_FREQ_MHZ = 125;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned NV_WRITE_TIME_US = 10000;
    localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned NV_CNT_W = 21;
    localparam int unsigned WIPER_SETTLE_NS = 40;
    localparam int unsigned WIPER_SETTLE_CYCLES =
        (WIPER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register geometry and values after reset.
    localparam int unsigned POS_W = 10;
    localparam int unsigned TAP_COUNT = 1024;
    localparam int unsigned STORED_COUNT = 4;
    localparam logic [9:0] STORED_RESET = 10'h000;
    localparam logic [1023:0] TAP_SEL_RESET = 1024'h1;

    // Pin vector positions and their levels after reset.
    localparam int unsigned PIN_W = 7;
    localparam int unsigned PIN_CS = 0;
    localparam int unsigned PIN_SCK = 1;
    localparam int unsigned PIN_SI = 2;
    localparam int unsigned PIN_HOLD = 3;
    localparam int unsigned PIN_WP = 4;
    localparam int unsigned PIN_ADDR = 5;
    localparam logic [6:0] PIN_RESET = 7'h19;

    // Identification and instruction byte fields.
    localparam int unsigned ID_TYPE_MSB = 7;
    localparam int unsigned ID_TYPE_LSB = 4;
    localparam int unsigned ID_ZERO_BIT = 3;
    localparam int unsigned ID_ADDR_MSB = 2;
    localparam int unsigned ID_ADDR_LSB = 1;
    localparam int unsigned ID_DIR_BIT = 0;
    localparam int unsigned SEL_MSB = 3;
    localparam int unsigned SEL_LSB = 2;
    localparam logic [3:0] OP_WIPER_RD = 4'h8;
    localparam logic [3:0] OP_WIPER_WR = 4'ha;
    localparam logic [3:0] OP_STORED_RD = 4'ha;
    localparam logic [3:0] OP_STORED_WR = 4'hc;
    localparam logic [3:0] OP_XFR_TO_WIPER = 4'hc;
    localparam logic [3:0] OP_XFR_TO_STORED = 4'he;
    localparam logic [7:0] INSTR_STATUS_RD = 8'h41;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] WORD_LAST = 4'hf;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_WIPER_RD,
        CMD_WIPER_WR,
        CMD_STORED_RD,
        CMD_STORED_WR,
        CMD_XFR_TO_WIPER,
        CMD_XFR_TO_STORED,
        CMD_STATUS_RD
    } swrc_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ID,
        ST_INSTR,
        ST_DATA,
        ST_DONE,
        ST_IGNORE
    } swrc_state_t;

    function automatic swrc_cmd_t decode_cmd(input logic rd,
                                             input logic [7:0] instr);
        logic [3:0] op;
        logic low_zero;
        logic sel_zero;
        op = instr[7:4];
        low_zero = (instr[1:0] == 2'h0);
        sel_zero = (instr[3:2] == 2'h0);
        decode_cmd = CMD_NONE;
        if (rd && instr == INSTR_STATUS_RD) begin
            decode_cmd = CMD_STATUS_RD;
        end else if (low_zero) begin
            if (rd && op == OP_WIPER_RD && sel_zero) begin
                decode_cmd = CMD_WIPER_RD;
            end else if (!rd && op == OP_WIPER_WR && sel_zero) begin
                decode_cmd = CMD_WIPER_WR;
            end else if (rd && op == OP_STORED_RD) begin
                decode_cmd = CMD_STORED_RD;
            end else if (!rd && op == OP_STORED_WR) begin
                decode_cmd = CMD_STORED_WR;
            end else if (rd && op == OP_XFR_TO_WIPER) begin
                decode_cmd = CMD_XFR_TO_WIPER;
            end else if (!rd && op == OP_XFR_TO_STORED) begin
                decode_cmd = CMD_XFR_TO_STORED;
            end
        end
    endfunction

endpackage

`default_nettype wire

/* hw/swrc_top.sv */
// Serial command logic of a single resistor tap selector with four stored
// positions. Assumes every pin arrives asynchronously to clk and that the
// serial clock is much slower than clk (at least four clk cycles per phase).
// Contract
// - Input bits are sampled on the serial clock rising edge.
// - Wiper value decodes to exactly one of 1024 tap switches.
// - After reset the wiper loads from stored position zero.
// - Four 10-bit stored positions, readable, writable, exchangeable.
// - Every stored-position change is a write cycle of at most 10 ms.
// - Read-only busy flag is 1 during a write cycle, else 0.
// - First byte after select falls is the identification byte.
// - Address bits must match the address pins or the command is dropped.
// - Identification LSB gives direction, 1 read and 0 write.
// - Instruction byte holds opcode, then two register select bits.
// - Wiper read is 1/0x80; wiper write is 0/0xa0 with data.
// - Stored read is 1/0xa_; stored write is 0/0xc_ and non-volatile.
// - 1/0xc_ copies stored to wiper; 0/0xe_ copies wiper to stored.
// - Status read 1/0x41 returns busy in the LSB, other bits zero.
// - Reads, writes and status use four bytes: id, instruction, two data.
// - Both transfer commands end after id and instruction bytes.
// - Wiper loads reach the tap after a settle delay; saves take time.
// - Saves start, and busy rises, only when select rises after completion.
// - Read data shifts out on falling edges; output off while deselected.
// - Protect input low blocks all stored-position writes.
// - Pause low freezes the sequence without resetting it.
`default_nettype none

module swrc_top #(
    parameter int unsigned NV_WRITE_CYCLES = swrc_pkg::NV_WRITE_CYCLES,
    parameter logic [3:0] TYPE_ID = 4'h9 // Arbitrary value.
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Serial bus pins.
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic [1:0] slave_address_bits,
    output logic so,
    output logic so_oe,
    // Tap switch enables.
    output logic [1023:0] tap_sel_q
);

    logic [6:0] pins;
    logic [6:0] pin_lvl;
    logic cs_lvl;
    logic sck_lvl;
    logic si_lvl;
    logic hold_lvl;
    logic wp_lvl;
    logic [1:0] addr_lvl;
    logic cs_prev_q;
    logic sck_prev_q;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    swrc_pkg::swrc_state_t state_q;
    swrc_pkg::swrc_cmd_t cmd_q;
    swrc_pkg::swrc_cmd_t cmd_d;
    logic [3:0] bit_cnt_q;
    logic [15:0] in_q;
    logic [15:0] in_d;
    logic dir_rd_q;
    logic [1:0] sel_q;
    logic [15:0] shout_q;
    logic so_q;
    logic [9:0] wiper_position_q;
    logic [9:0] stored_position_q [4];
    logic load_pending_q;
    logic exec;
    logic nv_start;
    logic wiper_we;
    logic [9:0] wiper_wdata;
    logic write_state_q;
    logic [20:0] nv_cnt_q;
    logic settle_pend_q;
    logic [3:0] settle_cnt_q;

    assign pins = {slave_address_bits, wp_n, hold_n, si, sck, cs_n};

    swrc_pin_filter #(
        .W(swrc_pkg::PIN_W),
        .RST(swrc_pkg::PIN_RESET)
    ) u_pins (
        .clk(clk),
        .arst_n(arst_n),
        .pin_in(pins),
        .level_q(pin_lvl)
    );

    assign cs_lvl = pin_lvl[swrc_pkg::PIN_CS];
    assign sck_lvl = pin_lvl[swrc_pkg::PIN_SCK];
    assign si_lvl = pin_lvl[swrc_pkg::PIN_SI];
    assign hold_lvl = pin_lvl[swrc_pkg::PIN_HOLD];
    assign wp_lvl = pin_lvl[swrc_pkg::PIN_WP];
    assign addr_lvl = pin_lvl[swrc_pkg::PIN_ADDR +: 2];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_prev_q <= 1'b1;
            sck_prev_q <= 1'b0;
        end else begin
            cs_prev_q <= cs_lvl;
            sck_prev_q <= sck_lvl;
        end
    end

    // Serial clock edges count only while selected and not paused.
    assign cs_fall = cs_prev_q && !cs_lvl;
    assign cs_rise = !cs_prev_q && cs_lvl;
    assign sck_rise = !cs_lvl && hold_lvl && sck_lvl && !sck_prev_q;
    assign sck_fall = !cs_lvl && hold_lvl && !sck_lvl && sck_prev_q;

    assign in_d = {in_q[14:0], si_lvl};
    assign cmd_d = swrc_pkg::decode_cmd(dir_rd_q, in_d[7:0]);

    // Sequencer. Nothing runs until a select falling edge has been seen.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= swrc_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            in_q <= 16'h0000;
            dir_rd_q <= 1'b0;
            sel_q <= 2'h0;
            cmd_q <= swrc_pkg::CMD_NONE;
        end else if (cs_rise) begin
            state_q <= swrc_pkg::ST_IDLE;
        end else if (cs_fall) begin
            state_q <= swrc_pkg::ST_ID;
            bit_cnt_q <= 4'h0;
        end else if (sck_rise) begin
            in_q <= in_d;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            case (state_q)
                swrc_pkg::ST_ID: begin
                    if (bit_cnt_q == swrc_pkg::BYTE_LAST) begin
                        bit_cnt_q <= 4'h0;
                        dir_rd_q <= in_d[swrc_pkg::ID_DIR_BIT];
                        if (in_d[swrc_pkg::ID_TYPE_MSB:swrc_pkg::ID_TYPE_LSB]
                                == TYPE_ID
                                && !in_d[swrc_pkg::ID_ZERO_BIT]
                                && in_d[swrc_pkg::ID_ADDR_MSB:
                                        swrc_pkg::ID_ADDR_LSB]
                                == addr_lvl) begin
                            state_q <= swrc_pkg::ST_INSTR;
                        end else begin
                            state_q <= swrc_pkg::ST_IGNORE;
                        end
                    end
                end
                swrc_pkg::ST_INSTR: begin
                    if (bit_cnt_q == swrc_pkg::BYTE_LAST) begin
                        bit_cnt_q <= 4'h0;
                        cmd_q <= cmd_d;
                        sel_q <= in_d[swrc_pkg::SEL_MSB:swrc_pkg::SEL_LSB];
                        case (cmd_d)
                            swrc_pkg::CMD_NONE:
                                state_q <= swrc_pkg::ST_IGNORE;
                            swrc_pkg::CMD_XFR_TO_WIPER,
                            swrc_pkg::CMD_XFR_TO_STORED:
                                state_q <= swrc_pkg::ST_DONE;
                            default:
                                state_q <= swrc_pkg::ST_DATA;
                        endcase
                    end
                end
                swrc_pkg::ST_DATA: begin
                    if (bit_cnt_q == swrc_pkg::WORD_LAST) begin
                        state_q <= swrc_pkg::ST_DONE;
                    end
                end
                default: begin
                    bit_cnt_q <= bit_cnt_q;
                    in_q <= in_q;
                end
            endcase
        end
    end

    // Read data: loaded after the instruction byte, shifted on falling edges.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shout_q <= 16'h0000;
            so_q <= 1'b0;
        end else if (sck_rise && state_q == swrc_pkg::ST_INSTR
                     && bit_cnt_q == swrc_pkg::BYTE_LAST) begin
            case (cmd_d)
                swrc_pkg::CMD_WIPER_RD:
                    shout_q <= {6'h00, wiper_position_q};
                swrc_pkg::CMD_STORED_RD:
                    shout_q <= {6'h00, stored_position_q[in_d[3:2]]};
                swrc_pkg::CMD_STATUS_RD:
                    shout_q <= {15'h0000, write_state_q};
                default:
                    shout_q <= 16'h0000;
            endcase
        end else if (sck_fall && state_q == swrc_pkg::ST_DATA
                     && dir_rd_q) begin
            so_q <= shout_q[15];
            shout_q <= {shout_q[14:0], 1'b0};
        end
    end

    assign so = so_q;
    assign so_oe = !cs_lvl && hold_lvl && dir_rd_q
                   && state_q == swrc_pkg::ST_DATA;

    // Commands act only when select rises after a complete sequence.
    assign exec = cs_rise && state_q == swrc_pkg::ST_DONE;
    assign nv_start = exec && wp_lvl && !write_state_q
                      && (cmd_q == swrc_pkg::CMD_STORED_WR
                          || cmd_q == swrc_pkg::CMD_XFR_TO_STORED);

    always_comb begin
        wiper_we = 1'b0;
        wiper_wdata = in_q[9:0];
        if (exec && cmd_q == swrc_pkg::CMD_WIPER_WR) begin
            wiper_we = 1'b1;
        end else if (exec && cmd_q == swrc_pkg::CMD_XFR_TO_WIPER) begin
            wiper_we = 1'b1;
            wiper_wdata = stored_position_q[sel_q];
        end
    end

    // The wiper copy of stored position zero is taken one cycle after reset.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            load_pending_q <= 1'b1;
            wiper_position_q <= swrc_pkg::STORED_RESET;
        end else if (load_pending_q) begin
            load_pending_q <= 1'b0;
            wiper_position_q <= stored_position_q[0];
        end else if (wiper_we) begin
            wiper_position_q <= wiper_wdata;
        end
    end

    // Stored positions. Reset stands in for the contents kept across power.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < int'(swrc_pkg::STORED_COUNT); i++) begin
                stored_position_q[i] <= swrc_pkg::STORED_RESET;
            end
        end else if (nv_start) begin
            if (cmd_q == swrc_pkg::CMD_STORED_WR) begin
                stored_position_q[sel_q] <= in_q[9:0];
            end else begin
                stored_position_q[sel_q] <= wiper_position_q;
            end
        end
    end

    // Write cycle timer. A save requested while busy is dropped, since the
    // array cannot take a second high-voltage cycle on top of the first.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            write_state_q <= 1'b0;
            nv_cnt_q <= 21'h0;
        end else if (nv_start) begin
            write_state_q <= 1'b1;
            nv_cnt_q <= 21'h0;
        end else if (write_state_q) begin
            if (nv_cnt_q == 21'(NV_WRITE_CYCLES - 1)) begin
                write_state_q <= 1'b0;
            end else begin
                nv_cnt_q <= nv_cnt_q + 21'h1;
            end
        end
    end

    // Tap follows the wiper after the settle delay.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_pend_q <= 1'b0;
            settle_cnt_q <= 4'h0;
            tap_sel_q <= swrc_pkg::TAP_SEL_RESET;
        end else if (load_pending_q || wiper_we) begin
            settle_pend_q <= 1'b1;
            settle_cnt_q <= 4'(swrc_pkg::WIPER_SETTLE_CYCLES);
        end else if (settle_pend_q) begin
            if (settle_cnt_q == 4'h1) begin
                settle_pend_q <= 1'b0;
                tap_sel_q <= 1024'h1 << wiper_position_q;
            end else begin
                settle_cnt_q <= settle_cnt_q - 4'h1;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_tap_onehot: assert property ($onehot(tap_sel_q))
        else $error("tap enables not one-hot");
    chk_so_off: assert property (
            so_oe |-> !cs_lvl
            && (cmd_q == swrc_pkg::CMD_WIPER_RD
                || cmd_q == swrc_pkg::CMD_STORED_RD
                || cmd_q == swrc_pkg::CMD_STATUS_RD))
        else $error("serial output driven outside a read");
    chk_busy_rise: assert property (nv_start |=> write_state_q [*8])
        else $error("busy flag not held after save start");
    chk_busy_bound: assert property (
            write_state_q |-> nv_cnt_q < 21'(NV_WRITE_CYCLES))
        else $error("write cycle overran");
    chk_save_cause: assert property (
            $rose(write_state_q) |-> $past(cs_rise) && $past(wp_lvl))
        else $error("save started without select rise");
    chk_protect: assert property (
            !wp_lvl |=> $stable(stored_position_q[0])
            && $stable(stored_position_q[1])
            && $stable(stored_position_q[2])
            && $stable(stored_position_q[3]))
        else $error("stored position written while protected");
    chk_powerup_load: assert property (
            load_pending_q
            |=> wiper_position_q == $past(stored_position_q[0]))
        else $error("wiper not loaded from stored zero");
    chk_pause_freeze: assert property (
            !hold_lvl && !cs_fall && !cs_rise
            |=> $stable(bit_cnt_q) && $stable(state_q) && $stable(in_q))
        else $error("sequence moved while paused");
    chk_ignore_silent: assert property (
            state_q == swrc_pkg::ST_IGNORE |-> !so_oe && !exec)
        else $error("ignored command had an effect");
    chk_tap_settle: assert property (
            wiper_we |-> ##[1:8] tap_sel_q == 1024'h1 << wiper_position_q)
        else $error("tap did not follow wiper");
    chk_sample_edge: assert property ($changed(in_q) |-> $past(sck_rise))
        else $error("input shifted off the rising edge");

    cov_wiper_read: cover property (sck_fall
            && cmd_q == swrc_pkg::CMD_WIPER_RD);
    cov_pause_clock: cover property (!hold_lvl && !cs_lvl
            && sck_lvl && !sck_prev_q);
    cov_stored_save: cover property (nv_start
            && cmd_q == swrc_pkg::CMD_STORED_WR);
    cov_xfr_wiper: cover property (exec
            && cmd_q == swrc_pkg::CMD_XFR_TO_WIPER);
    cov_status_busy: cover property (so_oe && write_state_q
            && cmd_q == swrc_pkg::CMD_STATUS_RD);

endmodule

`default_nettype wire

/* testbench/swrc_master.sv */
// Behavioural serial bus master that frames commands for the tap selector.
// Assumes the bench clock; every pin moves just after a rising clk edge.
`default_nettype none

module swrc_master (
    // Clock used only to time the pins.
    input wire logic clk,
    // Serial bus pins.
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    output logic wp_n,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic oe_seen;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
        oe_seen = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic set_protect(input logic level);
        @(posedge clk);
        wp_n <= level;
    endtask

    // Shifts nbits of word MSB first, 96 ns per bit, and gathers so.
    // A pause is held before bit pause_at, entered and left with sck low.
    task automatic frame(input int nbits, input logic [31:0] word,
                         input int pause_at, output logic [15:0] rd);
        rd = 16'h0;
        oe_seen = 1'b0;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            tick(4);
            if (i == pause_at) begin
                hold_n <= 1'b0;
                tick(4);
                // The clock runs on during a pause and must be ignored.
                sck <= 1'b1;
                tick(4);
                sck <= 1'b0;
                tick(4);
                hold_n <= 1'b1;
                tick(4);
            end
            si <= word[31 - i];
            tick(4);
            oe_seen = oe_seen | (so_oe === 1'b1);
            // A line nobody drives reads as the inverse of the last bit.
            rd = {rd[14:0], (so_oe === 1'b1) ? so : ~rd[0]};
            sck <= 1'b1;
            tick(4);
            sck <= 1'b0;
        end
        tick(4);
        cs_n <= 1'b1;
        si <= ~si;
        tick(8);
    endtask
endmodule

`default_nettype wire

/* testbench/swrc_test.sv */
// Self-checking bench for the tap selector command logic.
// Assumes the master model carries all pin traffic but the address pins; save time is shortened.
`default_nettype none

`define CHECK(got, exp) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("unexpected at %0t: %0h, expected %0h", $time, got, exp); \
    end \
end

module swrc_test;
    timeunit 1ns;
    timeprecision 1ps;

    // Long enough that busy is still up for the status read that follows.
    localparam int unsigned NV_CYC = 2000;
    localparam logic [3:0] TID = 4'h6; // Arbitrary value.
    localparam logic [1:0] ADDR = 2'h2;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] addr_pins = ADDR;
    logic cs_n, sck, si, hold_n, wp_n, so, so_oe;
    logic [1023:0] tap_sel_q;
    logic [15:0] r;
    logic [9:0] vals [4] = '{10'h3a1, 10'h0c3, 10'h3ff, 10'h15c};
    int mismatches = 0;
    int n_tests = 0;

    always #4 clk = ~clk;

    swrc_top #(.NV_WRITE_CYCLES(NV_CYC), .TYPE_ID(TID)) swrc_top_inst (
        .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .slave_address_bits(addr_pins),
        .so(so), .so_oe(so_oe), .tap_sel_q(tap_sel_q)
    );

    swrc_master swrc_master_inst (
        .clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .wp_n(wp_n), .so(so), .so_oe(so_oe)
    );

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic cmd(input logic dir, input logic [7:0] ins,
                       input int nbits, input logic [15:0] data);
        swrc_master_inst.frame(nbits, {TID, 1'b0, ADDR, dir, ins, data},
                               -1, r);
    endtask

    // Polls status until the save is over; gives up after 20 reads.
    task automatic wait_idle();
        for (int k = 0; k < 20; k++) begin
            cmd(1'b1, 8'h41, 32, 16'h0);
            if (r === 16'h0000) return;
            repeat (100) @(posedge clk);
        end
        mismatches++;
        $display("unexpected at %0t: busy never cleared", $time);
        print_verdict();
    endtask

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk);
        `CHECK(tap_sel_q, 1024'h1)
        cmd(1'b1, 8'h80, 32, 16'h0);
        `CHECK(r, 16'h0000)
        end_test("reset");

        swrc_master_inst.frame(32, {TID, 1'b0, ADDR, 1'b0, 8'ha0, 16'hfea5},
                               20, r);
        repeat (20) @(posedge clk);
        `CHECK(tap_sel_q, 1024'h1 << 10'h2a5)
        cmd(1'b1, 8'h80, 32, 16'h0);
        `CHECK(r, 16'h02a5)
        `CHECK(so_oe, 1'b0)
        end_test("wiper");

        for (int k = 0; k < 4; k++) begin
            cmd(1'b0, {4'hc, 2'(k), 2'h0}, 32, {6'h0, vals[k]});
            cmd(1'b1, 8'h41, 32, 16'h0);
            `CHECK(r, 16'h0001)
            wait_idle();
        end
        for (int k = 0; k < 4; k++) begin
            cmd(1'b1, {4'ha, 2'(k), 2'h0}, 32, 16'h0);
            `CHECK(r, {6'h0, vals[k]})
        end
        end_test("stored");

        cmd(1'b1, 8'hc8, 16, 16'h0);
        repeat (20) @(posedge clk);
        `CHECK(tap_sel_q, 1024'h1 << vals[2])
        cmd(1'b0, 8'hec, 16, 16'h0);
        cmd(1'b1, 8'h41, 32, 16'h0);
        `CHECK(r, 16'h0001)
        wait_idle();
        cmd(1'b1, 8'hac, 32, 16'h0);
        `CHECK(r, {6'h0, vals[2]})
        end_test("transfer");

        swrc_master_inst.set_protect(1'b0);
        cmd(1'b0, 8'hc4, 32, 16'h0111);
        cmd(1'b1, 8'h41, 32, 16'h0);
        `CHECK(r, 16'h0000)
        swrc_master_inst.set_protect(1'b1);
        cmd(1'b1, 8'ha4, 32, 16'h0);
        `CHECK(r, {6'h0, vals[1]})
        end_test("protect");

        addr_pins <= 2'h1;
        cmd(1'b1, 8'h80, 32, 16'h0);
        `CHECK(swrc_master_inst.oe_seen, 1'b0)
        cmd(1'b0, 8'ha0, 32, 16'h0011);
        addr_pins <= ADDR;
        swrc_master_inst.frame(32, {~TID, 1'b0, ADDR, 1'b0, 8'ha0, 16'h22},
                               -1, r);
        cmd(1'b0, 8'h80, 32, 16'h0033);
        cmd(1'b0, 8'ha0, 24, 16'h0044);
        cmd(1'b0, 8'hc0, 24, 16'h0055);
        cmd(1'b1, 8'h41, 32, 16'h0);
        `CHECK(r, 16'h0000)
        cmd(1'b1, 8'h80, 32, 16'h0);
        `CHECK(r, {6'h0, vals[2]})
        `CHECK(tap_sel_q, 1024'h1 << vals[2])
        end_test("refusal");
        print_verdict();
    end
endmodule

`default_nettype wire
